// file: include/tpc_pkg.sv
/*
  Constants, field layout and shared decoding for the timer/prescaler
  configuration register. Assumes one synchronous clock and reset.
*/
// Operation
// - The configuration register is six bits wide, written by software and never read back.
// - The register-load instruction copies the working accumulator into the register.
// - Every device reset sets all six implemented bits to one.
// - Bits 7 and 6 are not implemented and always show zero.
// - Bit 5 picks the timer source, one for the external pin and zero for instruction cycles.
// - One prescaler is shared, bit 3 gives it to the watchdog when one and the timer when zero.
package tpc_pkg;
  localparam int CFG_W = 6;
  localparam logic [5:0] CFG_RESET = 6'h3F;
  localparam logic [1:0] CFG_UNIMPL = 2'h0;
  localparam int SRC_BIT = 5;
  localparam int EDGE_BIT = 4;
  localparam int ASSIGN_BIT = 3;
  localparam int RATE_MSB = 2;
  localparam int RATE_LSB = 0;
  localparam int PRESC_W = 8;
  localparam logic [7:0] PRESC_RESET = 8'h00;
  localparam logic [8:0] EVCNT_RESET = 9'h000;

  // Low-bit mask of a power-of-two division by 2^e
  function automatic logic [7:0] tpc_rate_mask(input logic [3:0] e);
    logic [8:0] full;
    full = (9'h001 << e) - 9'h001;
    return full[7:0];
  endfunction : tpc_rate_mask
endpackage : tpc_pkg

// file: include/tpc_presc_if.sv
/*
  Link between the configuration block and its shared prescaler.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface tpc_presc_if;
  logic countEvent;
  logic clear;
  logic [3:0] exponent;
  logic tick;
  modport ctrl (output countEvent, output clear, output exponent, input tick);
  modport presc (input countEvent, input clear, input exponent, output tick);
endinterface : tpc_presc_if

// file: rtl/tpc_prescaler.sv
/*
  Shared power-of-two prescaler: one tick out per 2^exponent events in.
  Assumes exponent only changes together with clear.
*/
`timescale 1ns/10ps
module tpc_prescaler
  import tpc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  tpc_presc_if.presc bus
);
  logic [7:0] count_reg;
  logic [7:0] count_next;

  // Terminal count reached on an event; a clear swallows the event
  always_comb begin
    bus.tick = bus.countEvent && !bus.clear && (count_reg == tpc_rate_mask(bus.exponent));
    count_next = count_reg;
    if (bus.clear) begin
      count_next = PRESC_RESET;
    end else if (bus.countEvent) begin
      count_next = bus.tick ? PRESC_RESET : count_reg + 8'h01;
    end
  end

  // Counter register
  always_ff @(posedge clock) begin
    if (reset) begin
      count_reg <= PRESC_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // Counter never passes the terminal value
  count_bound_a: assert property (@(posedge clock) disable iff (reset)
    count_reg <= tpc_rate_mask(bus.exponent))
    else $error("prescaler count beyond terminal value");
endmodule : tpc_prescaler

// file: rtl/tpc_option_reg.sv
/*
  Write-only timer/prescaler configuration register with the source,
  edge and prescaler routing it steers. Assumes the core gives a one-cycle
  load strobe with the accumulator, and that the pin, instruction-cycle
  and watchdog ticks are synchronous to clock.
*/
`timescale 1ns/10ps
module tpc_option_reg
  import tpc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic loadOption,
  input wire logic [7:0] accumulator,
  input wire logic instrCycleTick,
  input wire logic timerExtClockPin,
  input wire logic watchdogRawTick,
  output logic timerSourceSelect,
  output logic timerEdgeSelect,
  output logic prescaleAssign,
  output logic [2:0] prescaleRate,
  output logic [7:0] configView,
  output logic timerTick,
  output logic watchdogTick
);
  logic [5:0] cfg_reg;
  logic [5:0] cfg_next;
  logic pinPrev_reg;
  logic pinPrev_next;
  logic timerTick_reg;
  logic timerTick_next;
  logic watchdogTick_reg;
  logic watchdogTick_next;
  logic [8:0] evCount_reg;
  logic [8:0] evCount_next;
  logic [8:0] wdCount_reg;
  logic [8:0] wdCount_next;
  logic extEdge;
  logic srcEvent;

  tpc_presc_if prescBus ();

  tpc_prescaler uPrescaler (
    .clock(clock),
    .reset(reset),
    .bus(prescBus.presc)
  );

  // Configuration register: loaded only by the load strobe, no read path
  always_comb begin
    cfg_next = cfg_reg;
    if (loadOption) begin
      cfg_next = accumulator[CFG_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_reg <= CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Field decode for the timer and watchdog logic
  assign timerSourceSelect = cfg_reg[SRC_BIT];
  assign timerEdgeSelect = cfg_reg[EDGE_BIT];
  assign prescaleAssign = cfg_reg[ASSIGN_BIT];
  assign prescaleRate = cfg_reg[RATE_MSB:RATE_LSB];
  assign configView = {CFG_UNIMPL, cfg_reg};

  // Previous pin level for edge detection
  always_comb begin
    pinPrev_next = timerExtClockPin;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pinPrev_reg <= 1'b0;
    end else begin
      pinPrev_reg <= pinPrev_next;
    end
  end

  // Edge and source selection
  always_comb begin
    extEdge = timerEdgeSelect ? (pinPrev_reg && !timerExtClockPin)
                              : (!pinPrev_reg && timerExtClockPin);
    srcEvent = timerSourceSelect ? extEdge : instrCycleTick;
  end

  // Prescaler routing; a load restarts the count so a new ratio starts clean
  always_comb begin
    prescBus.countEvent = prescaleAssign ? watchdogRawTick : srcEvent;
    prescBus.exponent = prescaleAssign ? {1'b0, prescaleRate}
                                       : {1'b0, prescaleRate} + 4'h1;
    prescBus.clear = loadOption;
  end

  // Tick outputs: the party without the prescaler takes its source directly
  always_comb begin
    timerTick_next = prescaleAssign ? srcEvent : prescBus.tick;
    watchdogTick_next = prescaleAssign ? prescBus.tick : watchdogRawTick;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      timerTick_reg <= 1'b0;
      watchdogTick_reg <= 1'b0;
    end else begin
      timerTick_reg <= timerTick_next;
      watchdogTick_reg <= watchdogTick_next;
    end
  end

  assign timerTick = timerTick_reg;
  assign watchdogTick = watchdogTick_reg;

  // Checker count of timer-side prescaler inputs between output ticks
  always_comb begin
    evCount_next = evCount_reg;
    if (loadOption) begin
      evCount_next = EVCNT_RESET;
    end else if (prescBus.countEvent && !prescaleAssign) begin
      evCount_next = prescBus.tick ? EVCNT_RESET : evCount_reg + 9'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      evCount_reg <= EVCNT_RESET;
    end else begin
      evCount_reg <= evCount_next;
    end
  end

  // Checker count of watchdog-side prescaler inputs between output ticks
  always_comb begin
    wdCount_next = wdCount_reg;
    if (loadOption) begin
      wdCount_next = EVCNT_RESET;
    end else if (watchdogRawTick && prescaleAssign) begin
      wdCount_next = prescBus.tick ? EVCNT_RESET : wdCount_reg + 9'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wdCount_reg <= EVCNT_RESET;
    end else begin
      wdCount_reg <= wdCount_next;
    end
  end

  // Steps of the pin edge, instruction-cycle and load paths
  sequence rise_seq;
    timerSourceSelect && !timerEdgeSelect && prescaleAssign
      && !pinPrev_reg && timerExtClockPin;
  endsequence

  sequence fall_seq;
    timerSourceSelect && timerEdgeSelect && prescaleAssign
      && pinPrev_reg && !timerExtClockPin;
  endsequence

  sequence internal_seq;
    !timerSourceSelect && prescaleAssign && instrCycleTick;
  endsequence

  sequence load_seq;
    loadOption ##1 1'b1;
  endsequence

  load_copy_a: assert property (@(posedge clock) disable iff (reset)
    loadOption |=> (cfg_reg == $past(accumulator[5:0])))
    else $error("load did not copy accumulator");

  reset_ones_a: assert property (@(posedge clock)
    reset |=> (configView == {CFG_UNIMPL, CFG_RESET}))
    else $error("reset did not set configuration bits");

  hold_value_a: assert property (@(posedge clock) disable iff (reset)
    !loadOption |=> (cfg_reg == $past(cfg_reg)))
    else $error("configuration changed without load");

  upper_zero_a: assert property (@(posedge clock) disable iff (reset)
    load_seq |-> (configView[7:6] == CFG_UNIMPL) && (configView[5:0] == $past(accumulator[5:0])))
    else $error("unimplemented bits not zero");

  rise_edge_a: assert property (@(posedge clock) disable iff (reset)
    rise_seq |=> timerTick)
    else $error("rising pin edge missed");

  fall_edge_a: assert property (@(posedge clock) disable iff (reset)
    fall_seq |=> timerTick)
    else $error("falling pin edge missed");

  wrong_edge_a: assert property (@(posedge clock) disable iff (reset)
    (timerSourceSelect && prescaleAssign
      && ((pinPrev_reg == timerExtClockPin) || (timerExtClockPin == timerEdgeSelect)))
      |=> !timerTick)
    else $error("timer ticked without a selected pin edge");

  internal_src_a: assert property (@(posedge clock) disable iff (reset)
    internal_seq |=> timerTick)
    else $error("instruction cycle not counted");

  watchdog_direct_a: assert property (@(posedge clock) disable iff (reset)
    (!prescaleAssign && watchdogRawTick) |=> watchdogTick)
    else $error("watchdog tick lost with prescaler on timer");

  watchdog_unity_a: assert property (@(posedge clock) disable iff (reset)
    (prescaleAssign && prescaleRate == 3'h0 && watchdogRawTick && !loadOption)
      |=> watchdogTick)
    else $error("watchdog 1:1 ratio not passed through");

  timer_ratio_a: assert property (@(posedge clock) disable iff (reset)
    (prescBus.tick && !prescaleAssign)
      |-> ((evCount_reg + 9'h001) == (9'h001 << ({1'b0, prescaleRate} + 4'h1))))
    else $error("timer division ratio wrong");

  // Watchdog ratio when it owns the prescaler
  watchdog_ratio_a: assert property (@(posedge clock) disable iff (reset)
    (prescBus.tick && prescaleAssign)
      |-> ((wdCount_reg + 9'h001) == (9'h001 << prescaleRate)))
    else $error("watchdog division ratio wrong");

  // Idle sources must leave the tick outputs low
  pin_ignored_a: assert property (@(posedge clock) disable iff (reset)
    (!timerSourceSelect && prescaleAssign && !instrCycleTick) |=> !timerTick)
    else $error("timer ticked without an instruction cycle");

  watchdog_quiet_a: assert property (@(posedge clock) disable iff (reset)
    !watchdogRawTick |=> !watchdogTick)
    else $error("watchdog ticked without a base tick");
endmodule : tpc_option_reg

// file: verification/tpc_core_model.sv
/*
  Core-side model that issues the register-load instruction.
  Assumes the bench calls load just after a clock edge.
*/
`timescale 1ns/10ps
module tpc_core_model (
  input wire logic clock,
  output logic loadOption,
  output logic [7:0] accumulator
);
  // Idle with the strobe low and a filler accumulator value
  initial begin
    loadOption = 1'b0;
    accumulator = 8'hA5;
  end

  // One load per cycle, back to back; the accumulator moves on afterwards
  task automatic load(input logic [7:0] vals[$]);
    foreach (vals[i]) begin
      @(posedge clock);
      #1;
      loadOption = 1'b1;
      accumulator = vals[i];
    end
    @(posedge clock);
    #1;
    loadOption = 1'b0;
    accumulator = ~accumulator;
  endtask : load
endmodule : tpc_core_model

// file: verification/test_timer_prescaler_config_reg.sv
/*
  Testbench for tpc_option_reg: loads, reset values, ratios and pin edges.
  Assumes the core model issues loads and the bench drives the tick inputs.
*/
`timescale 1ns/10ps
module test_timer_prescaler_config_reg
  import tpc_pkg::*;
;
  logic clock, reset, instrCycleTick, timerExtClockPin, watchdogRawTick, loadOption;
  logic timerSourceSelect, timerEdgeSelect, prescaleAssign, timerTick, watchdogTick;
  logic [7:0] accumulator, configView;
  logic [2:0] prescaleRate;
  int num_errors = 0;
  int check_count = 0;
  int tCnt = 0;
  int wCnt = 0;
  logic [7:0] rows [6][2] = '{'{8'hC0, 8'h00}, '{8'h0A, 8'h0A}, '{8'hFF, 8'h3F},
                              '{8'h35, 8'h35}, '{8'h6A, 8'h2A}, '{8'h95, 8'h15}};

  tpc_option_reg u_dut (.clock(clock), .reset(reset), .loadOption(loadOption),
    .accumulator(accumulator), .instrCycleTick(instrCycleTick),
    .timerExtClockPin(timerExtClockPin), .watchdogRawTick(watchdogRawTick),
    .timerSourceSelect(timerSourceSelect), .timerEdgeSelect(timerEdgeSelect),
    .prescaleAssign(prescaleAssign), .prescaleRate(prescaleRate),
    .configView(configView), .timerTick(timerTick), .watchdogTick(watchdogTick));
  tpc_core_model u_core (.clock(clock), .loadOption(loadOption), .accumulator(accumulator));

  // Free-running core clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Count the tick pulses seen on each output
  always @(posedge clock) begin
    if (timerTick === 1'b1) tCnt++;
    if (watchdogTick === 1'b1) wCnt++;
  end

  // Compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Field outputs gathered in register order
  function automatic logic [7:0] fields();
    return {2'h0, timerSourceSelect, timerEdgeSelect, prescaleAssign, prescaleRate};
  endfunction : fields

  // Pulse the chosen inputs for n cycles, then let the last tick land
  task automatic pulse(input int n, input logic ic, input logic wd, input logic pin);
    tCnt = 0;
    wCnt = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      instrCycleTick = ic;
      watchdogRawTick = wd;
      if (pin) timerExtClockPin = ~timerExtClockPin;
    end
    @(posedge clock);
    #1;
    instrCycleTick = 1'b0;
    watchdogRawTick = 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask : pulse

  // Print counts and the verdict, then stop
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // Cut a hang short
  initial begin
    #200us;
    num_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    end_of_test();
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    instrCycleTick = 1'b0;
    watchdogRawTick = 1'b0;
    timerExtClockPin = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    reset = 1'b0;
    check(configView, 8'h3F, "reset view");
    check(fields(), 8'h3F, "reset fields");
    for (int i = 0; i < 6; i++) begin
      u_core.load('{rows[i][0]});
      check(configView, rows[i][1], "loaded view");
      check(fields(), rows[i][1], "loaded fields");
    end
    $display("load rows done");
    u_core.load('{8'h11, 8'h2C});
    check(configView, 8'h2C, "last load wins");
    @(posedge clock);
    #1;
    reset = 1'b1;
    @(posedge clock);
    #1;
    check(configView, 8'h3F, "mid-run reset");
    check(fields(), 8'h3F, "mid-run reset fields");
    reset = 1'b0;
    $display("reset test done");
    for (int r = 0; r < 8; r++) begin
      u_core.load('{8'(r)});
      pulse(4 << r, 1'b1, 1'b1, 1'b0);
      check(16'(tCnt), 16'h2, "timer prescaled");
      check(16'(wCnt), 16'(4 << r), "watchdog direct");
      u_core.load('{8'(8 + r)});
      pulse(2 << r, 1'b1, 1'b1, 1'b0);
      check(16'(wCnt), 16'h2, "watchdog prescaled");
      check(16'(tCnt), 16'(2 << r), "timer direct");
    end
    $display("ratio test done");
    u_core.load('{8'h38});
    pulse(7, 1'b1, 1'b0, 1'b1);
    check(16'(tCnt), 16'h3, "falling pin edges");
    u_core.load('{8'h28});
    pulse(7, 1'b1, 1'b0, 1'b1);
    check(16'(tCnt), 16'h3, "rising pin edges");
    u_core.load('{8'h30});
    pulse(8, 1'b1, 1'b1, 1'b1);
    check(16'(tCnt), 16'h2, "prescaled falling edges");
    check(16'(wCnt), 16'h8, "watchdog beside pin");
    $display("pin test done");
    end_of_test();
  end
endmodule : test_timer_prescaler_config_reg
